// ==== rtl/fhc_codec.sv ====
// Summary of operation
// - element starts with type and length byte
// - unknown or reserved elements skipped by length
// - fragmentation element: type 3, length 5
// - key sequence and version 1 first
// - encryption enable and key toggle bits
// - fourteen-bit service identifier of fragment
// - eight-bit piggyback mini-slot request
// - last byte opens with two zero bits
// - first and last flags per fragment
// - fragment sequence increments per fragment
// - suppression byte first, sync byte second
// - service flow type 5 down, 6 up
// - index zero means no suppression
// - absent element or zero index: suppression off
// - index scope: per identifier up, modem down
// - suppressed strings of 64 to 255 bytes; shorter ones still suppressed, flagged short
// - upstream suppression starts right after check
// - downstream suppression starts at thirteenth byte
// - unfragmented encryption starts at thirteenth byte
// - packet crc covers only transmitted bytes
// - grant sync form: type 6, length 2
// - queue bit and seven-bit active grants
// - sync byte only for unsolicited grant flows
// - modem side does suppression and restoration
`timescale 1ns/1ps
`default_nettype none
`include "fhc_map.svh"

module fhc_codec
  import fhc_pkg::*;
#(
  parameter int IDXW = 16,
  parameter logic [7:0] MIN_SUP_LEN = 8'h40
)
(
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // element build request
  input wire logic i_tx_frag_req,
  input wire logic i_tx_sf_req,
  input wire logic [3:0] i_key_seq,
  input wire logic i_enc_enable,
  input wire logic i_key_toggle,
  input wire logic [13:0] i_sid,
  input wire logic [7:0] i_req_slots,
  input wire logic i_frag_first,
  input wire logic i_frag_last,
  input wire logic [3:0] i_frag_seq_start,
  input wire logic [7:0] i_sup_index,
  input wire logic i_ugs_sched,
  input wire logic i_queue_ind,
  input wire logic [6:0] i_active_grants,
  output logic o_tx_busy,
  // built element byte stream
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  output logic o_tx_last,
  // received element byte stream
  input wire logic i_rx_valid,
  input wire logic i_rx_start,
  input wire logic [7:0] i_rx_byte,
  // parsed fragmentation element
  output logic o_rx_frag_valid,
  output logic [3:0] o_rx_key_seq,
  output logic o_rx_ver_ok,
  output logic o_rx_enc_enable,
  output logic o_rx_key_toggle,
  output logic [13:0] o_rx_sid,
  output logic [7:0] o_rx_req_slots,
  output logic o_rx_frag_first,
  output logic o_rx_frag_last,
  output logic [3:0] o_rx_frag_seq,
  // parsed service flow element
  output logic o_rx_sf_valid,
  output logic o_rx_sf_per_sid,
  output logic [7:0] o_rx_sup_index,
  output logic o_rx_sync_present,
  output logic o_rx_queue_ind,
  output logic [6:0] o_rx_active_grants,
  output logic o_rx_sup_on,
  // payload byte classification
  input wire logic i_pay_valid,
  input wire logic [IDXW-1:0] i_pay_idx,
  input wire logic i_pay_down,
  input wire logic i_frag_active,
  input wire logic [7:0] i_pay_sup_index,
  input wire logic [7:0] i_pay_sup_len,
  output logic o_pay_valid,
  output logic o_pay_suppressed,
  output logic o_pay_encrypt,
  output logic o_pay_crc_include,
  output logic o_pay_sup_short
);

  function automatic logic [7:0] eh_byte(input logic [3:0] t, input logic [3:0] l);
    eh_byte = {t, l};
  endfunction

  function automatic logic at_or_after(input logic [IDXW-1:0] idx, input logic [15:0] start);
    at_or_after = ({16'h0000, idx} >= {{IDXW{1'b0}}, start});
  endfunction

  // element builder
  fhc_bld_state_t bst_q, bst_d;
  logic [47:0] buf_q, buf_d;
  logic [2:0] cnt_q, cnt_d;
  logic [3:0] seq_q, seq_d, seq_use;
  logic [39:0] fval;
  logic busy_q, busy_d;
  logic tv_q, tv_d, tl_q, tl_d;
  logic [7:0] tb_q, tb_d;
  logic slot_free;

  always_comb begin
    bst_d = bst_q;
    buf_d = buf_q;
    cnt_d = cnt_q;
    seq_d = seq_q;
    tv_d = tv_q && !i_tx_ready;
    tl_d = tl_q;
    tb_d = tb_q;
    slot_free = !tv_q || i_tx_ready;
    seq_use = i_frag_first ? i_frag_seq_start : seq_q + 4'h1;
    fval = 40'h0;
    fval[`FHC_F_KEY] = i_key_seq;
    fval[`FHC_F_VER] = `FHC_VERSION;
    fval[`FHC_F_ENA] = i_enc_enable;
    fval[`FHC_F_TGL] = i_key_toggle;
    fval[`FHC_F_SID] = i_sid;
    fval[`FHC_F_REQ] = i_req_slots;
    fval[`FHC_F_RSV] = `FHC_RSV_ZERO;
    fval[`FHC_F_FIRST] = i_frag_first;
    fval[`FHC_F_LAST] = i_frag_last;
    fval[`FHC_F_SEQ] = seq_use;
    case (bst_q)
      FHC_B_IDLE: begin
        if (i_tx_frag_req) begin
          buf_d = {eh_byte(`FHC_TYPE_FRAG, `FHC_LEN_FRAG), fval};
          cnt_d = `FHC_BYTES_FRAG;
          seq_d = seq_use;
          bst_d = FHC_B_SEND;
        end else if (i_tx_sf_req) begin
          if (i_ugs_sched) begin
            buf_d = {eh_byte(`FHC_TYPE_SF_UP, `FHC_LEN_SF2), i_sup_index,
                     i_queue_ind, i_active_grants, 24'h000000};
            cnt_d = `FHC_BYTES_SF2;
          end else begin
            buf_d = {eh_byte(`FHC_TYPE_SF_UP, `FHC_LEN_SF1), i_sup_index, 32'h00000000};
            cnt_d = `FHC_BYTES_SF1;
          end
          bst_d = FHC_B_SEND;
        end
      end
      FHC_B_SEND: begin
        if (slot_free) begin
          tv_d = 1'b1;
          tb_d = buf_q[47:40];
          tl_d = (cnt_q == `FHC_CNT_ONE);
          buf_d = {buf_q[39:0], 8'h00};
          cnt_d = cnt_q - 3'h1;
          if (cnt_q == `FHC_CNT_ONE) begin
            bst_d = FHC_B_IDLE;
          end
        end
      end
      default: begin
        bst_d = FHC_B_IDLE;
      end
    endcase
    busy_d = (bst_d == FHC_B_SEND) || tv_d;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      bst_q <= FHC_B_IDLE;
      buf_q <= 48'h000000000000;
      cnt_q <= 3'h0;
      seq_q <= 4'h0;
      busy_q <= 1'b0;
      tv_q <= 1'b0;
      tl_q <= 1'b0;
      tb_q <= 8'h00;
    end else if (i_ce) begin
      bst_q <= bst_d;
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      seq_q <= seq_d;
      busy_q <= busy_d;
      tv_q <= tv_d;
      tl_q <= tl_d;
      tb_q <= tb_d;
    end
  end

  assign o_tx_busy = busy_q;
  assign o_tx_valid = tv_q;
  assign o_tx_byte = tb_q;
  assign o_tx_last = tl_q;

  // element parser
  fhc_elem_parser u_parser (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_rx_valid(i_rx_valid),
    .i_rx_start(i_rx_start),
    .i_rx_byte(i_rx_byte),
    .o_frag_valid(o_rx_frag_valid),
    .o_key_seq(o_rx_key_seq),
    .o_ver_ok(o_rx_ver_ok),
    .o_enc_enable(o_rx_enc_enable),
    .o_key_toggle(o_rx_key_toggle),
    .o_sid(o_rx_sid),
    .o_req_slots(o_rx_req_slots),
    .o_frag_first(o_rx_frag_first),
    .o_frag_last(o_rx_frag_last),
    .o_frag_seq(o_rx_frag_seq),
    .o_sf_valid(o_rx_sf_valid),
    .o_sf_per_sid(o_rx_sf_per_sid),
    .o_sup_index(o_rx_sup_index),
    .o_sync_present(o_rx_sync_present),
    .o_queue_ind(o_rx_queue_ind),
    .o_active_grants(o_rx_active_grants),
    .o_sup_on(o_rx_sup_on)
  );

  // payload region marking
  logic pv_q, pv_d, ps_q, ps_d, pe_q, pe_d, pc_q, pc_d, pshort_q, pshort_d;
  logic [15:0] sup_start, sup_end, enc_start;
  logic sup_on, in_sup;

  always_comb begin
    sup_start = i_pay_down ? `FHC_DN_SUP_START : `FHC_UP_SUP_START;
    sup_end = sup_start + {8'h00, i_pay_sup_len};
    enc_start = i_frag_active ? `FHC_ENC_START_FRAG : `FHC_ENC_START_NOFRAG;
    sup_on = (i_pay_sup_index != `FHC_SUP_OFF);
    in_sup = sup_on && at_or_after(i_pay_idx, sup_start) && !at_or_after(i_pay_idx, sup_end);
    pv_d = i_pay_valid;
    ps_d = i_pay_valid && in_sup;
    pe_d = i_pay_valid && at_or_after(i_pay_idx, enc_start);
    pc_d = i_pay_valid && !in_sup;
    pshort_d = sup_on && (i_pay_sup_len < MIN_SUP_LEN) && (i_pay_sup_len != 8'h00);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pv_q <= 1'b0;
      ps_q <= 1'b0;
      pe_q <= 1'b0;
      pc_q <= 1'b0;
      pshort_q <= 1'b0;
    end else if (i_ce) begin
      pv_q <= pv_d;
      ps_q <= ps_d;
      pe_q <= pe_d;
      pc_q <= pc_d;
      pshort_q <= pshort_d;
    end
  end

  assign o_pay_valid = pv_q;
  assign o_pay_suppressed = ps_q;
  assign o_pay_encrypt = pe_q;
  assign o_pay_crc_include = pc_q;
  assign o_pay_sup_short = pshort_q;

endmodule

`default_nettype wire

// ==== rtl/fhc_elem_parser.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fhc_map.svh"

module fhc_elem_parser
  import fhc_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // received extended header bytes
  input wire logic i_rx_valid,
  input wire logic i_rx_start,
  input wire logic [7:0] i_rx_byte,
  // fragmentation element
  output logic o_frag_valid,
  output logic [3:0] o_key_seq,
  output logic o_ver_ok,
  output logic o_enc_enable,
  output logic o_key_toggle,
  output logic [13:0] o_sid,
  output logic [7:0] o_req_slots,
  output logic o_frag_first,
  output logic o_frag_last,
  output logic [3:0] o_frag_seq,
  // service flow element
  output logic o_sf_valid,
  output logic o_sf_per_sid,
  output logic [7:0] o_sup_index,
  output logic o_sync_present,
  output logic o_queue_ind,
  output logic [6:0] o_active_grants,
  output logic o_sup_on
);

  fhc_prs_state_t st_q, st_d;
  logic [3:0] type_q, type_d, len_q, len_d, cnt_q, cnt_d;
  logic [39:0] val_q, val_d, newv;
  logic fv_q, fv_d, sv_q, sv_d, sup_q, sup_d, ver_q, ver_d;
  logic [39:0] fr_q, fr_d;
  logic sid_scope_q, sid_scope_d, sync_q, sync_d, queue_q, queue_d;
  logic [7:0] idx_q, idx_d;
  logic [6:0] gr_q, gr_d;

  always_comb begin
    st_d = st_q;
    type_d = type_q;
    len_d = len_q;
    cnt_d = cnt_q;
    val_d = val_q;
    fv_d = 1'b0;
    sv_d = 1'b0;
    sup_d = sup_q;
    fr_d = fr_q;
    ver_d = ver_q;
    sid_scope_d = sid_scope_q;
    sync_d = sync_q;
    queue_d = queue_q;
    idx_d = idx_q;
    gr_d = gr_q;
    newv = {val_q[31:0], i_rx_byte};
    if (i_rx_valid) begin
      if (i_rx_start) begin
        sup_d = 1'b0;
      end
      if (i_rx_start || st_q == FHC_P_HDR) begin
        type_d = i_rx_byte[`FHC_ELEMENT_TYPE];
        len_d = i_rx_byte[`FHC_ELEMENT_VALUE_LENGTH];
        cnt_d = 4'h0;
        val_d = 40'h0;
        st_d = (i_rx_byte[`FHC_ELEMENT_VALUE_LENGTH] == `FHC_LEN_NONE) ? FHC_P_HDR : FHC_P_VAL;
      end else begin
        val_d = newv;
        cnt_d = cnt_q + 4'h1;
        if (cnt_q + 4'h1 == len_q) begin
          st_d = FHC_P_HDR;
          if (type_q == `FHC_TYPE_FRAG && len_q == `FHC_LEN_FRAG) begin
            fv_d = 1'b1;
            fr_d = newv;
            ver_d = (newv[`FHC_F_VER] == `FHC_VERSION);
          end
          if ((type_q == `FHC_TYPE_SF_DN || type_q == `FHC_TYPE_SF_UP) && len_q == `FHC_LEN_SF1) begin
            sv_d = 1'b1;
            idx_d = newv[7:0];
            sync_d = 1'b0;
            sid_scope_d = (type_q == `FHC_TYPE_SF_UP);
            sup_d = (newv[7:0] != `FHC_SUP_OFF);
          end
          if (type_q == `FHC_TYPE_SF_UP && len_q == `FHC_LEN_SF2) begin
            sv_d = 1'b1;
            idx_d = newv[15:8];
            sync_d = 1'b1;
            queue_d = newv[`FHC_S_QUEUE];
            gr_d = newv[`FHC_S_GRANTS];
            sid_scope_d = 1'b1;
            sup_d = (newv[15:8] != `FHC_SUP_OFF);
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_q <= FHC_P_HDR;
      type_q <= 4'h0;
      len_q <= 4'h0;
      cnt_q <= 4'h0;
      val_q <= 40'h0;
      fv_q <= 1'b0;
      sv_q <= 1'b0;
      sup_q <= 1'b0;
      fr_q <= 40'h0;
      ver_q <= 1'b0;
      sid_scope_q <= 1'b0;
      sync_q <= 1'b0;
      queue_q <= 1'b0;
      idx_q <= 8'h00;
      gr_q <= 7'h00;
    end else if (i_ce) begin
      st_q <= st_d;
      type_q <= type_d;
      len_q <= len_d;
      cnt_q <= cnt_d;
      val_q <= val_d;
      fv_q <= fv_d;
      sv_q <= sv_d;
      sup_q <= sup_d;
      fr_q <= fr_d;
      ver_q <= ver_d;
      sid_scope_q <= sid_scope_d;
      sync_q <= sync_d;
      queue_q <= queue_d;
      idx_q <= idx_d;
      gr_q <= gr_d;
    end
  end

  assign o_frag_valid = fv_q;
  assign o_key_seq = fr_q[`FHC_F_KEY];
  assign o_ver_ok = ver_q;
  assign o_enc_enable = fr_q[`FHC_F_ENA];
  assign o_key_toggle = fr_q[`FHC_F_TGL];
  assign o_sid = fr_q[`FHC_F_SID];
  assign o_req_slots = fr_q[`FHC_F_REQ];
  assign o_frag_first = fr_q[`FHC_F_FIRST];
  assign o_frag_last = fr_q[`FHC_F_LAST];
  assign o_frag_seq = fr_q[`FHC_F_SEQ];
  assign o_sf_valid = sv_q;
  assign o_sf_per_sid = sid_scope_q;
  assign o_sup_index = idx_q;
  assign o_sync_present = sync_q;
  assign o_queue_ind = queue_q;
  assign o_active_grants = gr_q;
  assign o_sup_on = sup_q;

endmodule

`default_nettype wire

// ==== rtl/fhc_map.svh ====
`ifndef FHC_MAP_SVH
`define FHC_MAP_SVH

// element header byte layout
`define FHC_ELEMENT_TYPE 7:4
`define FHC_ELEMENT_VALUE_LENGTH 3:0
// element types and value lengths
`define FHC_TYPE_FRAG 4'h3
`define FHC_LEN_FRAG 4'h5
`define FHC_TYPE_SF_DN 4'h5
`define FHC_TYPE_SF_UP 4'h6
`define FHC_LEN_SF1 4'h1
`define FHC_LEN_SF2 4'h2
`define FHC_LEN_NONE 4'h0
`define FHC_VERSION 4'h1
// fragmentation value, 40 bits, first value byte on top
`define FHC_F_KEY 39:36
`define FHC_F_VER 35:32
`define FHC_F_ENA 31
`define FHC_F_TGL 30
`define FHC_F_SID 29:16
`define FHC_F_REQ 15:8
`define FHC_F_RSV 7:6
`define FHC_F_FIRST 5
`define FHC_F_LAST 4
`define FHC_F_SEQ 3:0
`define FHC_RSV_ZERO 2'h0
// service flow value
`define FHC_S_QUEUE 7
`define FHC_S_GRANTS 6:0
`define FHC_SUP_OFF 8'h00
// payload offsets after the header check sequence
`define FHC_UP_SUP_START 16'h0000
`define FHC_DN_SUP_START 16'h000c
`define FHC_ENC_START_NOFRAG 16'h000c
`define FHC_ENC_START_FRAG 16'h0000
// byte counts of built elements
`define FHC_BYTES_FRAG 3'h6
`define FHC_BYTES_SF1 3'h2
`define FHC_BYTES_SF2 3'h3
`define FHC_CNT_ONE 3'h1

`endif

// ==== rtl/fhc_pkg.sv ====
package fhc_pkg;

  typedef enum logic [0:0] {
    FHC_B_IDLE = 1'b0,
    FHC_B_SEND = 1'b1
  } fhc_bld_state_t;

  typedef enum logic [0:0] {
    FHC_P_HDR = 1'b0,
    FHC_P_VAL = 1'b1
  } fhc_prs_state_t;

endpackage

// ==== testbench/fhc_codec_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module fhc_codec_monitor #(
  parameter int IDXW = 16
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // builder
  input wire logic i_tx_frag_req,
  input wire logic i_tx_sf_req,
  input wire logic i_ugs_sched,
  input wire logic o_tx_busy,
  input wire logic i_tx_ready,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_byte,
  input wire logic o_tx_last,
  // parser
  input wire logic o_rx_frag_valid,
  input wire logic o_rx_sf_valid,
  // payload
  input wire logic i_pay_valid,
  input wire logic [IDXW-1:0] i_pay_idx,
  input wire logic i_pay_down,
  input wire logic i_frag_active,
  input wire logic [7:0] i_pay_sup_index,
  input wire logic [7:0] i_pay_sup_len,
  input wire logic o_pay_valid,
  input wire logic o_pay_suppressed,
  input wire logic o_pay_encrypt,
  input wire logic o_pay_crc_include,
  input wire logic o_pay_sup_short
);
  logic [IDXW:0] st;
  logic pv, sup, enc, shrt;
  assign st = i_pay_down ? (IDXW+1)'(8'h0c) : '0;
  assign pv = i_pay_valid && i_ce && !i_sys_rst;
  assign sup = |i_pay_sup_index && {1'b0, i_pay_idx} >= st
    && {1'b0, i_pay_idx} < st + (IDXW+1)'(i_pay_sup_len);
  assign enc = i_frag_active || i_pay_idx >= IDXW'(8'h0c);
  assign shrt = |i_pay_sup_index && |i_pay_sup_len && i_pay_sup_len < 8'h40;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  a_tx_hold: assert property (
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte) && $stable(o_tx_last))
    else $error("tx byte not held");
  a_frag_hdr: assert property (
    !o_tx_busy && i_tx_frag_req && i_ce ##1 i_ce [*2] |-> o_tx_valid && o_tx_byte == 8'h35)
    else $error("fragment header wrong");
  a_sf_hdr: assert property (
    !o_tx_busy && !i_tx_frag_req && i_tx_sf_req && i_ce ##1 i_ce [*2] |->
      o_tx_valid && o_tx_byte == {6'h18, $past(i_ugs_sched, 2), !$past(i_ugs_sched, 2)})
    else $error("service flow header wrong");
  a_valid_busy: assert property (o_tx_valid |-> o_tx_busy)
    else $error("valid without busy");
  a_rx_pulse: assert property (
    (o_rx_frag_valid || o_rx_sf_valid) && i_ce |=> !o_rx_frag_valid && !o_rx_sf_valid)
    else $error("decode pulse too long");
  a_pay_crc: assert property (o_pay_crc_include == (o_pay_valid && !o_pay_suppressed))
    else $error("crc flag wrong");
  a_pay_sup: assert property ($past(pv) |-> o_pay_suppressed == $past(sup))
    else $error("suppress flag wrong");
  a_pay_enc: assert property ($past(pv) |-> o_pay_encrypt == $past(enc))
    else $error("encrypt flag wrong");
  a_pay_short: assert property ($past(pv) |-> o_pay_sup_short == $past(shrt))
    else $error("short flag wrong");
endmodule
`default_nettype wire

// ==== testbench/fhc_peer_sink.sv ====
`timescale 1ns/1ps
`default_nettype none
module fhc_peer_sink (
  // clock
  input wire logic i_clk_sys,
  // stall control and accept
  input wire logic i_stall,
  output logic o_ready
);
  initial o_ready = 1'b0;
  always @(posedge i_clk_sys) begin
    o_ready <= i_stall ? 1'($urandom) : 1'b1;
  end
endmodule
`default_nettype wire

// ==== testbench/tb_fhc_codec.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_fhc_codec;
  // design inputs
  logic i_clk_sys = '0, i_sys_rst = 1'b1, i_ce = 1'b1, i_tx_frag_req = '0, i_tx_sf_req = '0, i_enc_enable = '0;
  logic i_key_toggle = '0, i_frag_first = '0, i_frag_last = '0, i_ugs_sched = '0, i_queue_ind = '0, i_tx_ready;
  logic i_rx_valid = '0, i_rx_start = '0, i_pay_valid = '0, i_pay_down = '0, i_frag_active = '0, stall = '0;
  logic [3:0] i_key_seq = '0, i_frag_seq_start = '0;
  logic [13:0] i_sid = '0;
  logic [7:0] i_req_slots = '0, i_sup_index = '0, i_rx_byte = '0, i_pay_sup_index = '0, i_pay_sup_len = '0;
  logic [6:0] i_active_grants = '0;
  logic [15:0] i_pay_idx = '0;
  // design outputs
  logic o_tx_busy, o_tx_valid, o_tx_last, o_rx_frag_valid, o_rx_ver_ok, o_rx_enc_enable, o_rx_key_toggle;
  logic o_rx_frag_first, o_rx_frag_last, o_rx_sf_valid, o_rx_sf_per_sid, o_rx_sync_present, o_rx_queue_ind;
  logic o_rx_sup_on, o_pay_valid, o_pay_suppressed, o_pay_encrypt, o_pay_crc_include, o_pay_sup_short;
  logic [7:0] o_tx_byte, o_rx_req_slots, o_rx_sup_index;
  logic [3:0] o_rx_key_seq, o_rx_frag_seq;
  logic [13:0] o_rx_sid;
  logic [6:0] o_rx_active_grants;
  // expected results
  logic [8:0] qtx[$];
  logic [34:0] qfr[$];
  logic [17:0] qsf[$];
  logic [3:0] qpy[$];
  int errors = 0, samples_checked = 0, cycles = 0;
  logic ce_gap = '0;
  logic [7:0] qg = '0;
  fhc_codec u_fhc_codec (.*);
  fhc_peer_sink u_fhc_peer_sink (.i_clk_sys(i_clk_sys), .i_stall(stall), .o_ready(i_tx_ready));
  initial begin
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // random clock-enable gaps while ce_gap is set
  always @(posedge i_clk_sys) begin
    i_ce <= !ce_gap || 1'($urandom);
  end
  task automatic stop_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cmp(input logic [34:0] e, input logic [34:0] g);
    samples_checked++;
    if (e !== g) begin
      errors++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic cmp_tx(input logic [8:0] e, input logic [8:0] g);
    cmp(35'(e), 35'(g));
  endtask
  task automatic cmp_sf(input logic [17:0] e, input logic [17:0] g);
    cmp(35'(e), 35'(g));
  endtask
  task automatic cmp_py(input logic [3:0] e, input logic [3:0] g);
    cmp(35'(e), 35'(g));
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do @(posedge i_clk_sys);
    while ((o_tx_busy || qtx.size() > 0) && ++n < 100);
  endtask
  task automatic frag(input logic f, input logic l, input logic [3:0] sq);
    logic [39:0] v;
    v = 40'({$urandom, $urandom});
    v[35:32] = 4'h1;
    v[7:0] = {2'b00, f, l, sq};
    {i_key_seq, i_enc_enable, i_key_toggle, i_sid, i_req_slots} <= {v[39:36], v[31:8]};
    {i_frag_first, i_frag_last, i_frag_seq_start} <= {f, l, f ? sq : ~sq};
    i_tx_frag_req <= 1'b1;
    i_tx_sf_req <= f;
    qtx.push_back(9'h035);
    for (int i = 4; i >= 0; i--) qtx.push_back({i == 0, v[i*8 +: 8]});
    do @(posedge i_clk_sys);
    while (!o_tx_busy);
    i_tx_frag_req <= 1'b0;
    i_tx_sf_req <= 1'b0;
    wait_idle();
  endtask
  task automatic sfe(input logic [7:0] x, input logic u);
    logic [7:0] g;
    g = 8'($urandom);
    {i_sup_index, i_ugs_sched, i_queue_ind, i_active_grants} <= {x, u, g};
    i_tx_sf_req <= 1'b1;
    qtx.push_back({1'b0, 6'h18, u, !u});
    qtx.push_back({!u, x});
    if (u) qtx.push_back({1'b1, g});
    do @(posedge i_clk_sys);
    while (!o_tx_busy);
    i_tx_sf_req <= 1'b0;
    wait_idle();
  endtask
  task automatic rxb(input logic s, input logic [7:0] b);
    i_rx_valid <= 1'b1;
    i_rx_start <= s;
    i_rx_byte <= b;
    @(posedge i_clk_sys);
  endtask
  task automatic rxv(input logic s, input logic [7:0] h, input logic [39:0] v);
    rxb(s, h);
    for (int i = 32'(h[3:0]) - 1; i >= 0; i--) rxb(1'b0, v[i*8 +: 8]);
  endtask
  task automatic idle;
    i_rx_valid <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask
  always @(posedge i_clk_sys) begin
    logic [17:0] e;
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
    if (i_ce && o_tx_valid && i_tx_ready) cmp_tx(qtx.pop_front(), {o_tx_last, o_tx_byte});
    if (o_rx_frag_valid) cmp(qfr.pop_front(), {o_rx_key_seq, o_rx_ver_ok, o_rx_enc_enable,
      o_rx_key_toggle, o_rx_sid, o_rx_req_slots, o_rx_frag_first, o_rx_frag_last, o_rx_frag_seq});
    if (o_rx_sf_valid) begin
      e = qsf.pop_front();
      if (e[8]) qg = e[7:0];
      else e[7:0] = qg;
      cmp_sf(e, {o_rx_sf_per_sid, o_rx_sup_index, o_rx_sync_present, o_rx_queue_ind, o_rx_active_grants});
    end
    if (o_pay_valid) cmp_py(qpy.pop_front(),
      {o_pay_suppressed, o_pay_encrypt, o_pay_crc_include, o_pay_sup_short});
  end
  initial begin
    logic [39:0] v;
    logic [31:0] p;
    logic [15:0] ix, st;
    logic [7:0] x;
    logic s;
    logic [7:0] hd[8];
    hd = '{8'h35, 8'h73, 8'hf2, 8'h00, 8'h34, 8'h35, 8'h51, 8'h62};
    void'($urandom(32'h1bcee986));
    repeat (6) @(posedge i_clk_sys);
    i_sys_rst <= 1'b0;
    @(posedge i_clk_sys);
    frag(1'b1, 1'b0, 4'he);
    frag(1'b0, 1'b0, 4'hf);
    stall <= 1'b1;
    frag(1'b0, 1'b1, 4'h0);
    sfe(8'h00, 1'b0);
    sfe(8'hff, 1'b1);
    stall <= 1'b0;
    ce_gap <= 1'b1;
    sfe(8'h5a, 1'b1);
    ce_gap <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    for (int j = 0; j < 8; j++) begin
      v = 40'({$urandom, $urandom});
      v[35:32] = j == 0 ? 4'h1 : 4'h9;
      v[8] = 1'b1;
      if (hd[j] == 8'h35) v[7:6] = 2'b00;
      if (hd[j] == 8'h35) qfr.push_back({v[39:36], v[35:32] == 4'h1, v[31:8], v[5:0]});
      if (hd[j] == 8'h51) qsf.push_back({1'b0, v[7:0], 9'h000});
      if (hd[j] == 8'h62) qsf.push_back({1'b1, v[15:8], 1'b1, v[7:0]});
      rxv(j == 0, hd[j], v);
    end
    idle();
    cmp(35'h1, 35'(o_rx_sup_on));
    qsf.push_back(18'h0);
    rxv(1'b1, 8'h51, 40'h0);
    idle();
    cmp(35'h0, 35'(o_rx_sup_on));
    qsf.push_back({1'b1, 8'h07, 9'h000});
    rxv(1'b1, 8'h61, 40'h07);
    rxv(1'b1, 8'h00, 40'h0);
    idle();
    cmp(35'h0, 35'(o_rx_sup_on));
    for (int i = 0; i < 400; i++) begin
      p = $urandom;
      x = p[13:11] == 3'h0 ? 8'h00 : p[23:16];
      ix = 16'(p[10:4]);
      st = p[1] ? 16'h000c : 16'h0000;
      s = x != 8'h00 && ix >= st && ix < st + 16'(p[31:24]);
      {i_pay_valid, i_pay_down, i_frag_active} <= p[2:0];
      {i_pay_idx, i_pay_sup_index, i_pay_sup_len} <= {ix, x, p[31:24]};
      if (p[2]) qpy.push_back({s, p[0] || ix >= 16'h000c, !s,
        x != 8'h00 && p[31:24] != 8'h00 && p[31:24] < 8'h40});
      @(posedge i_clk_sys);
    end
    i_pay_valid <= 1'b0;
    repeat (4) @(posedge i_clk_sys);
    cmp(35'h0, 35'(qtx.size() + qfr.size() + qsf.size() + qpy.size()));
    stop_test();
  end
endmodule
bind fhc_codec fhc_codec_monitor #(.IDXW(IDXW)) u_fhc_codec_monitor (.*);
`default_nettype wire
